// >>> hw/irbm_map.svh
// Purpose: Register offsets, field positions, reset values for the iso receive / init block.
// Assumes: Byte addresses within the link register space.
// Notes: Definitions only.
`ifndef IRBM_MAP_SVH
`define IRBM_MAP_SVH
`define IRBM_EVT_SET_OFS 8'hA0
`define IRBM_EVT_CLR_OFS 8'hA4
`define IRBM_MSK_SET_OFS 8'hA8
`define IRBM_MSK_CLR_OFS 8'hAC
`define IRBM_INIT_BW_OFS 8'hB0
`define IRBM_INIT_CHHI_OFS 8'hB4
`define IRBM_BW_MSB 12
`define IRBM_BW_RST 13'h1333
`define IRBM_CHHI_RST 32'hFFFFFFFF
`define IRBM_CTX_RST 4'h0
`define IRBM_SUMMARY_BIT 7
`endif

// >>> hw/irbm_pkg.sv
// Purpose: Shared types for the iso receive interrupt and bus-management init block.
// Assumes: Nothing beyond the map header.
// Notes: Types only.
`default_nettype none
package irbm_pkg;
    typedef logic [31:0] irbm_word_t;
    typedef logic [12:0] irbm_bw_t;
endpackage : irbm_pkg
`default_nettype wire

// >>> hw/irbm_edge.sv
// Purpose: Rising-edge detector on each context interrupt line.
// Assumes: Lines are synchronous to clk_i.
// Notes: One generate loop, one flop per line.
`default_nettype none
module irbm_edge #(
    parameter int WIDTH = 4
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [WIDTH-1:0] level_i,
    output logic [WIDTH-1:0] rise_o
);
    logic [WIDTH-1:0] prev_q;

    generate
        for (genvar g = 0; g < WIDTH; g++) begin : g_line
            always_ff @(posedge clk_i) begin
                if (reset_i) begin
                    prev_q[g] <= 1'b0;
                end else begin
                    prev_q[g] <= level_i[g];
                end
            end
            // A held level produces one pulse only.
            assign rise_o[g] = level_i[g] & ~prev_q[g];
        end
    endgenerate
endmodule : irbm_edge
`default_nettype wire

// >>> hw/irbm_regs.sv
// Purpose: Iso receive per-context event/mask registers and bus-management init values.
// Assumes: Register port is synchronous; reads answer one cycle after the strobe.
// Notes: reset_i covers system and software reset; CSR loads happen on reload pulses.
`include "irbm_map.svh"
`default_nettype none
module irbm_regs
    import irbm_pkg::*;
#(
    parameter int CONTEXTS = 4
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic [CONTEXTS-1:0] ctx_cmd_done_i,
    input wire logic [CONTEXTS-1:0] ctx_cmd_irq_bits_i,
    input wire logic global_reset_i,
    input wire logic pci_reset_i,
    input wire logic bus_reset_i,
    input wire logic main_summary_mask_i,
    output logic rx_context_summary_event_o,
    output logic summary_irq_o,
    output logic [12:0] bandwidth_csr_o,
    output logic [31:0] channels_hi_csr_o,
    output logic csr_load_o
);
    if (CONTEXTS != 4) begin : g_bad_contexts
        $error("irbm_regs supports exactly four receive contexts");
    end

    logic [CONTEXTS-1:0] event_q;
    logic [CONTEXTS-1:0] event_d;
    logic [CONTEXTS-1:0] mask_q;
    logic [CONTEXTS-1:0] mask_d;
    logic [CONTEXTS-1:0] ctx_irq_q;
    irbm_bw_t init_bw_q;
    irbm_word_t init_chhi_q;
    irbm_word_t rdata_d;

    // Address decode.
    wire logic hit_evt_set = reg_addr_i == `IRBM_EVT_SET_OFS;
    wire logic hit_evt_clr = reg_addr_i == `IRBM_EVT_CLR_OFS;
    wire logic hit_msk_set = reg_addr_i == `IRBM_MSK_SET_OFS;
    wire logic hit_msk_clr = reg_addr_i == `IRBM_MSK_CLR_OFS;
    wire logic hit_bw = reg_addr_i == `IRBM_INIT_BW_OFS;
    wire logic hit_chhi = reg_addr_i == `IRBM_INIT_CHHI_OFS;

    // Only the low context bits take part in event and mask writes.
    wire logic [CONTEXTS-1:0] wr_bits = reg_wdata_i[CONTEXTS-1:0];
    wire logic [CONTEXTS-1:0] evt_set_w = (reg_wr_i && hit_evt_set) ? wr_bits : '0;
    wire logic [CONTEXTS-1:0] evt_clr_w = (reg_wr_i && hit_evt_clr) ? wr_bits : '0;
    wire logic [CONTEXTS-1:0] msk_set_w = (reg_wr_i && hit_msk_set) ? wr_bits : '0;
    wire logic [CONTEXTS-1:0] msk_clr_w = (reg_wr_i && hit_msk_clr) ? wr_bits : '0;

    // A context raises its line when a completed input command asks for an interrupt.
    wire logic [CONTEXTS-1:0] ctx_irq_d = ctx_cmd_done_i & ctx_cmd_irq_bits_i;
    logic [CONTEXTS-1:0] ctx_rise;

    irbm_edge #(
        .WIDTH(CONTEXTS)
    ) u_edge (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .level_i(ctx_irq_q),
        .rise_o(ctx_rise)
    );

    // Hardware and software sets win over a same-cycle clear.
    assign event_d = (event_q & ~evt_clr_w) | evt_set_w | ctx_rise;
    assign mask_d = (mask_q & ~msk_clr_w) | msk_set_w;

    // Each event bit stands for its own context as a summary cause.
    wire logic [CONTEXTS-1:0] masked_evt = event_q & mask_q;
    wire logic summary_d = |masked_evt;

    wire logic any_reload = global_reset_i | pci_reset_i | bus_reset_i;

    // Read multiplexer; unmapped offsets read zero.
    always_comb begin
        rdata_d = '0;
        if (hit_evt_set) begin
            rdata_d[CONTEXTS-1:0] = event_q;
        end else if (hit_evt_clr) begin
            rdata_d[CONTEXTS-1:0] = masked_evt;
        end else if (hit_msk_set || hit_msk_clr) begin
            rdata_d[CONTEXTS-1:0] = mask_q;
        end else if (hit_bw) begin
            rdata_d[`IRBM_BW_MSB:0] = init_bw_q;
        end else if (hit_chhi) begin
            rdata_d = init_chhi_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctx_irq_q <= `IRBM_CTX_RST;
            event_q <= `IRBM_CTX_RST;
            mask_q <= `IRBM_CTX_RST;
        end else begin
            ctx_irq_q <= ctx_irq_d;
            event_q <= event_d;
            mask_q <= mask_d;
        end
    end

    // Init values are untouched by a bus reset; only reset_i restores them.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            init_bw_q <= `IRBM_BW_RST;
            init_chhi_q <= `IRBM_CHHI_RST;
        end else if (reg_wr_i) begin
            if (hit_bw) begin
                init_bw_q <= reg_wdata_i[`IRBM_BW_MSB:0];
            end
            if (hit_chhi) begin
                init_chhi_q <= reg_wdata_i;
            end
        end
    end

    // CSR copies follow the init fields at each reload event.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            bandwidth_csr_o <= `IRBM_BW_RST;
            channels_hi_csr_o <= `IRBM_CHHI_RST;
            csr_load_o <= 1'b0;
        end else begin
            csr_load_o <= any_reload;
            if (any_reload) begin
                bandwidth_csr_o <= init_bw_q;
                channels_hi_csr_o <= init_chhi_q;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rx_context_summary_event_o <= 1'b0;
            summary_irq_o <= 1'b0;
            reg_rdata_o <= '0;
            reg_rvalid_o <= 1'b0;
        end else begin
            rx_context_summary_event_o <= summary_d;
            summary_irq_o <= summary_d & main_summary_mask_i;
            reg_rvalid_o <= reg_rd_i;
            reg_rdata_o <= reg_rd_i ? rdata_d : '0;
        end
    end

endmodule : irbm_regs
`default_nettype wire

// >>> testbench/irbm_regs_checker.sv
// Purpose: Port assertions for irbm_regs.
// Assumes: One clock; reset_i synchronous, high.
// Notes: Bound into every irbm_regs.
`default_nettype none
module irbm_regs_checker #(
    parameter int CONTEXTS = 4
) (
    input wire logic clk_i, reset_i, reg_wr_i, reg_rd_i, reg_rvalid_o,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i, reg_rdata_o, channels_hi_csr_o,
    input wire logic [CONTEXTS-1:0] ctx_cmd_done_i, ctx_cmd_irq_bits_i,
    input wire logic global_reset_i, pci_reset_i, bus_reset_i, main_summary_mask_i,
    input wire logic rx_context_summary_event_o, summary_irq_o, csr_load_o,
    input wire logic [12:0] bandwidth_csr_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    wire reload_w = global_reset_i | pci_reset_i | bus_reset_i;
    wire evt_rd_w = reg_rd_i && reg_addr_i inside {8'hA0, 8'hA4, 8'hA8, 8'hAC};
    chk_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read not answered");
    chk_idle_quiet: assert property (!reg_rd_i |=> !reg_rvalid_o && reg_rdata_o == 32'h0)
        else $error("read data without read");
    chk_evt_upper: assert property (evt_rd_w |=> reg_rdata_o[31:4] == 28'h0)
        else $error("event or mask upper bits set");
    chk_bw_upper: assert property (reg_rd_i && reg_addr_i == 8'hB0 |=> reg_rdata_o[31:13] == 19'h0)
        else $error("bandwidth upper bits set");
    chk_irq_mask: assert property (summary_irq_o |-> $past(main_summary_mask_i))
        else $error("interrupt while main mask low");
    chk_load_pulse: assert property (reload_w |=> csr_load_o)
        else $error("reload not flagged");
    chk_bw_hold: assert property (!csr_load_o |-> $stable(bandwidth_csr_o))
        else $error("bandwidth csr moved");
    chk_chhi_hold: assert property (!csr_load_o |-> $stable(channels_hi_csr_o))
        else $error("channels csr moved");
    cover property (reg_rd_i && reg_addr_i == 8'hA4);
    cover property (summary_irq_o);
    cover property (csr_load_o);
endmodule : irbm_regs_checker
bind irbm_regs irbm_regs_checker #(.CONTEXTS(CONTEXTS)) u_irbm_chk (
    .clk_i, .reset_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o,
    .reg_rvalid_o, .ctx_cmd_done_i, .ctx_cmd_irq_bits_i, .global_reset_i, .pci_reset_i,
    .bus_reset_i, .main_summary_mask_i, .rx_context_summary_event_o, .summary_irq_o,
    .bandwidth_csr_o, .channels_hi_csr_o, .csr_load_o);
`default_nettype wire

// >>> testbench/irbm_regs_tb.sv
// Purpose: Self-checking bench for irbm_regs.
// Assumes: Strobes last one cycle; reads answer one cycle later.
// Notes: Tests are sequences of register calls.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, reset_i = 1'b1, wr = 1'b0, rd = 1'b0, mm = 1'b1;
    logic [2:0] rl = 3'h0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, ch;
    logic [3:0] done = 4'h0, ibits = 4'h0;
    logic rvalid, sum, irq, load;
    logic [12:0] bw;
    int miscompares = 0, compares = 0;
    always #4 clk_i = ~clk_i;
    irbm_regs #(.CONTEXTS(4)) u_irbm_regs (
        .clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .ctx_cmd_done_i(done), .ctx_cmd_irq_bits_i(ibits), .global_reset_i(rl[0]),
        .pci_reset_i(rl[1]), .bus_reset_i(rl[2]), .main_summary_mask_i(mm),
        .rx_context_summary_event_o(sum), .summary_irq_o(irq), .bandwidth_csr_o(bw),
        .channels_hi_csr_o(ch), .csr_load_o(load));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_i);
        rd <= 1'b0;
        #1;
        cmp(rvalid === 1'b1 ? rdata : 32'hBAD0BAD0, exp);
    endtask : rd_reg
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : wait_cyc
    task automatic test_done;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done
    initial begin
        #20000;
        miscompares++;
        test_done();
    end
    initial begin
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        rd_reg(8'hB0, 32'h1333);
        rd_reg(8'hB4, 32'hFFFFFFFF);
        rd_reg(8'hA8, 32'h0);
        wr_reg(8'hA0, 32'hFFFFFFFF);
        rd_reg(8'hA0, 32'hF);
        rd_reg(8'hA4, 32'h0);
        wr_reg(8'hA8, 32'hFFFFFFFF);
        wr_reg(8'hAC, 32'hA);
        rd_reg(8'hAC, 32'h5);
        rd_reg(8'hA4, 32'h5);
        cmp({31'h0, sum}, 32'h1);
        cmp({31'h0, irq}, 32'h1);
        wr_reg(8'hA4, 32'hF);
        rd_reg(8'hA0, 32'h0);
        wait_cyc(2);
        cmp({31'h0, sum}, 32'h0);
        $display("test set_clear finished");
        @(posedge clk_i);
        done <= 4'h3;
        ibits <= 4'h2;
        wait_cyc(4);
        rd_reg(8'hA0, 32'h2);
        cmp({31'h0, sum}, 32'h0);
        wr_reg(8'hA8, 32'h2);
        wait_cyc(3);
        cmp({31'h0, irq}, 32'h1);
        @(posedge clk_i);
        mm <= 1'b0;
        wait_cyc(2);
        cmp({31'h0, irq}, 32'h0);
        wr_reg(8'hA4, 32'h2);
        wr_reg(8'hA0, 32'hFFFFFFF0);
        rd_reg(8'hA0, 32'h0);
        $display("test context finished");
        wr_reg(8'hB0, 32'hFFFFFFFF);
        rd_reg(8'hB0, 32'h1FFF);
        for (int k = 0; k < 3; k++) begin
            wr_reg(8'hB4, 32'hC0DE0000 + k);
            @(posedge clk_i);
            rl <= 3'h1 << k;
            @(posedge clk_i);
            rl <= 3'h0;
            #1;
            cmp(ch, 32'hC0DE0000 + k);
            cmp({31'h0, load}, 32'h1);
            cmp({19'h0, bw}, 32'h1FFF);
        end
        rd_reg(8'hB0, 32'h1FFF);
        rd_reg(8'hB4, 32'hC0DE0002);
        wr_reg(8'hC0, 32'hFFFFFFFF);
        rd_reg(8'hC0, 32'h0);
        @(posedge clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        rd_reg(8'hB0, 32'h1333);
        rd_reg(8'hB4, 32'hFFFFFFFF);
        $display("test reload finished");
        test_done();
    end
endmodule : testbench
`default_nettype wire
